// file: pkg/pwm_dac_pkg.sv
// Constants shared by the pulse-division PWM block.
package pwm_dac_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0]  OFS_DUTY       = 4'h0;
	localparam logic [3:0]  OFS_CTRL       = 4'h4;
	localparam logic [3:0]  OFS_STATUS     = 4'h8;
	localparam int          ADDR_W         = 4;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int          CTRL_ENABLE    = 0;
	localparam int          CTRL_CARRIER   = 1;
	localparam int          CTRL_INVERT    = 2;
	localparam int          CTRL_CLKSRC    = 3;
	localparam int          CTRL_PRESC_LO  = 4;
	localparam int          CTRL_PRESC_HI  = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [13:0] DUTY_RST       = 14'h0000;
	localparam logic [5:0]  STAGE_RST      = 6'h00;
	localparam logic [6:0]  CTRL_RST       = 7'h00;

	// ----------------------------------------
	// Duty layout and carrier geometry
	// ----------------------------------------
	localparam int          DUTY_W         = 14;
	localparam int          LARGE_LOC_W    = 6;
	localparam int          SMALL_LOC_W    = 8;
	localparam logic [7:0]  LARGE_UNIT_MAX = 8'hff;
	localparam logic [7:0]  SMALL_UNIT_MAX = 8'h3f;
	localparam logic [7:0]  LARGE_PULSE_MAX = 8'h3f;
	localparam logic [7:0]  SMALL_PULSE_MAX = 8'hff;

	// ----------------------------------------
	// Prescaler terminal counts (divide minus one)
	// ----------------------------------------
	localparam logic [13:0] DIV_TERM_1     = 14'h0000;
	localparam logic [13:0] DIV_TERM_2     = 14'h0001;
	localparam logic [13:0] DIV_TERM_64    = 14'h003f;
	localparam logic [13:0] DIV_TERM_128   = 14'h007f;
	localparam logic [13:0] DIV_TERM_256   = 14'h00ff;
	localparam logic [13:0] DIV_TERM_1024  = 14'h03ff;
	localparam logic [13:0] DIV_TERM_4096  = 14'h0fff;
	localparam logic [13:0] DIV_TERM_16384 = 14'h3fff;

	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

endpackage : pwm_dac_pkg

// file: hw/pwm_dac.sv
// Pulse-division PWM DAC with AXI4-Lite register slave.
//
// Contract
// [RL1] Duty word is total active-pulse width over 256 or 64 base pulses.
// [RL2] Inversion off: duty sets low time; inversion on: duty sets high time.
// [RL3] Large carrier: base pulse period is 256 resolution units.
// [RL4] Large carrier: top eight bits base width, low six bits locate extras.
// [RL5] Small carrier: period 64 units, top six bits width, low eight locate.
// [RL6] Base pulse active width equals top field in resolution units.
// [RL7] Each additional pulse lengthens its base pulse by exactly one unit.
// [RL8] Large carrier, location 000001: only base pulse 63 gets an extra.
// [RL9] Zeroed low duty bits shorten the effective conversion cycle.
// [RL10] Clock source 1, prescale 011..110 selects divide 256/1024/4096/16384.
// [RL11] Resolution unit is one prescaled period; counters run while enabled.
// [RL12] Output held at fixed level when duty is below pulse minimum.
// [RL13] Upper byte parks in staging; duty updates when lower byte follows.
module pwm_dac
(
	input  wire logic                           clock,
	input  wire logic                           sys_rst,
	input  wire logic [pwm_dac_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [pwm_dac_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	output logic                                pwm_output_pin
);
	import pwm_dac_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [DUTY_W-1:0]     pwmDutyWord_r;
	logic [DUTY_W-1:0]     dutyShadow_r;
	logic [5:0]            dutyStage_r;
	logic [6:0]            ctrl_r;
	logic                  awHave_r;
	logic                  wHave_r;
	logic [ADDR_W-1:0]     awAddr_r;
	logic [31:0]           wData_r;
	logic [3:0]            wStrb_r;
	logic [13:0]           prescaleCnt_r;
	logic [7:0]            unitCnt_r;
	logic [7:0]            pulseIdx_r;
	logic                  carrierShadow_r;

	wire                   enable                 = ctrl_r[CTRL_ENABLE];
	wire                   carrier_size_select    = ctrl_r[CTRL_CARRIER];
	wire                   output_polarity_invert = ctrl_r[CTRL_INVERT];
	wire                   clock_source_select    = ctrl_r[CTRL_CLKSRC];
	wire [2:0]             prescaler_control_reg  = ctrl_r[CTRL_PRESC_HI:CTRL_PRESC_LO];

	// ----------------------------------------
	// Write channel decode
	// ----------------------------------------
	wire                   awFire    = s_axi_awvalid & s_axi_awready;
	wire                   wFire     = s_axi_wvalid & s_axi_wready;
	wire                   writeGo   = awHave_r & wHave_r & ~s_axi_bvalid;
	wire                   bFire     = s_axi_bvalid & s_axi_bready;
	wire                   awHaveNxt = (awHave_r | awFire) & ~writeGo;
	wire                   wHaveNxt  = (wHave_r | wFire) & ~writeGo;
	wire                   bvalidNxt = writeGo | (s_axi_bvalid & ~bFire);
	wire                   wrDuty    = writeGo & (awAddr_r == OFS_DUTY);
	wire                   wrCtrl    = writeGo & (awAddr_r == OFS_CTRL);
	wire                   wrMapped  = wrDuty | wrCtrl | (awAddr_r == OFS_STATUS);
	wire                   upperLane = wStrb_r[1];
	wire                   lowerLane = wStrb_r[0];

	// Duty word assembly: the lower lane commits; a lone upper lane only stages.
	wire [5:0]             upperByte = upperLane ? wData_r[13:8] : dutyStage_r; // RL13
	wire [DUTY_W-1:0]      dutyNew   = {upperByte, wData_r[7:0]}; // RL13
	wire                   stageLoad = wrDuty & upperLane & ~lowerLane; // RL13
	wire                   dutyLoad  = wrDuty & lowerLane; // RL13

	// ----------------------------------------
	// Read channel decode
	// ----------------------------------------
	wire                   arFire    = s_axi_arvalid & s_axi_arready;
	wire                   rFire     = s_axi_rvalid & s_axi_rready;
	wire                   rvalidNxt = arFire | (s_axi_rvalid & ~rFire);
	wire                   rdDuty    = s_axi_araddr == OFS_DUTY;
	wire                   rdCtrl    = s_axi_araddr == OFS_CTRL;
	wire                   rdStatus  = s_axi_araddr == OFS_STATUS;
	wire                   rdMapped  = rdDuty | rdCtrl | rdStatus;
	wire [31:0]            statusWord = {15'h0000, pwm_output_pin, pulseIdx_r, unitCnt_r};
	wire [31:0]            rdMux =
		rdDuty   ? {18'h00000, pwmDutyWord_r} :
		rdCtrl   ? {25'h0000000, ctrl_r} :
		rdStatus ? statusWord : 32'h00000000;

	// ----------------------------------------
	// Resolution-unit prescaler
	// ----------------------------------------
	// Code 111 is prohibited; it falls onto the slowest divide rather than stall.
	wire [13:0]            divTerm =
		!clock_source_select           ? DIV_TERM_1 :
		prescaler_control_reg == 3'h0  ? DIV_TERM_2 :
		prescaler_control_reg == 3'h1  ? DIV_TERM_64 :
		prescaler_control_reg == 3'h2  ? DIV_TERM_128 :
		prescaler_control_reg == 3'h3  ? DIV_TERM_256 : // RL10
		prescaler_control_reg == 3'h4  ? DIV_TERM_1024 : // RL10
		prescaler_control_reg == 3'h5  ? DIV_TERM_4096 : // RL10
		DIV_TERM_16384; // RL10
	wire                   unitTick  = enable & (prescaleCnt_r >= divTerm); // RL11

	// ----------------------------------------
	// Carrier geometry
	// ----------------------------------------
	wire [7:0]             unitMax   = carrierShadow_r ? LARGE_UNIT_MAX : SMALL_UNIT_MAX; // RL3 RL5
	wire [7:0]             pulseMax  = carrierShadow_r ? LARGE_PULSE_MAX : SMALL_PULSE_MAX; // RL1
	// Compare with >= so a shorter carrier can never overrun its count
	wire                   unitLast  = unitCnt_r >= unitMax;
	wire                   pulseLast = pulseIdx_r >= pulseMax;
	wire                   cycleEnd  = unitTick & unitLast & pulseLast;

	// Base width: upper field of the duty word, in resolution units.
	wire [7:0]             baseWidth = carrierShadow_r ?
		dutyShadow_r[13:6] : // RL4
		{2'b00, dutyShadow_r[13:8]}; // RL5
	wire [LARGE_LOC_W-1:0] locLarge  = dutyShadow_r[LARGE_LOC_W-1:0]; // RL4
	wire [SMALL_LOC_W-1:0] locSmall  = dutyShadow_r[SMALL_LOC_W-1:0]; // RL5

	// ----------------------------------------
	// Additional-pulse spreading
	// ----------------------------------------
	// Bit-reversed countdown order spreads extras evenly; location 1 hits the
	// last base pulse only.
	logic [LARGE_LOC_W-1:0] revLarge;
	logic [SMALL_LOC_W-1:0] revSmall;

	genvar gi;
	generate
		for (gi = 0; gi < SMALL_LOC_W; gi++) begin : g_rev
			assign revSmall[gi] = ~pulseIdx_r[SMALL_LOC_W-1-gi];
			if (gi < LARGE_LOC_W) begin : g_large
				assign revLarge[gi] = ~pulseIdx_r[LARGE_LOC_W-1-gi];
			end
		end
	endgenerate

	wire                   extraLarge = revLarge < locLarge; // RL8
	wire                   extraSmall = revSmall < locSmall;
	wire                   extra      = carrierShadow_r ? extraLarge : extraSmall; // RL7

	// Active while the unit count sits inside base width plus an optional unit.
	wire [8:0]             activeLen = {1'b0, baseWidth} + {8'h00, extra}; // RL6 RL7
	// Zero base field holds the pin; extras alone never make a pulse
	wire                   belowMin  = baseWidth == 8'h00;
	wire                   active    = enable & ~belowMin & ({1'b0, unitCnt_r} < activeLen); // RL12
	// Active means low unless inverted, so duty is low time or high time.
	wire                   pinNxt    = active ~^ output_polarity_invert; // RL2

	// ----------------------------------------
	// Shadow load sources
	// ----------------------------------------
	// Enabling write must reach the shadows, else the first cycle runs stale
	wire                   shadowLoad  = ~enable | cycleEnd;
	wire                   carrierLive = (wrCtrl & lowerLane) ?
		wData_r[CTRL_CARRIER] : carrier_size_select;
	wire [DUTY_W-1:0]      dutyLive    = dutyLoad ? dutyNew : pwmDutyWord_r;

	// ----------------------------------------
	// Bus channel handshake
	// ----------------------------------------
	// Registered ready drops on the very edge that takes a request
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			awHave_r      <= 1'b0;
			wHave_r       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			awHave_r      <= awHaveNxt;
			wHave_r       <= wHaveNxt;
			s_axi_awready <= ~awHaveNxt & ~bvalidNxt;
			s_axi_wready  <= ~wHaveNxt & ~bvalidNxt;
			s_axi_bvalid  <= bvalidNxt;
			if (writeGo) begin
				s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Address and data may come in either order; each waits for its pair
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			awAddr_r <= '0;
			wData_r  <= 32'h00000000;
			wStrb_r  <= 4'h0;
		end else begin
			if (awFire) begin
				awAddr_r <= s_axi_awaddr;
			end
			if (wFire) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
		end
	end

	// One read in flight; arready returns when rvalid is accepted
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalidNxt;
			s_axi_rvalid  <= rvalidNxt;
			if (arFire) begin
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Control commits on the low lane only; status ignores writes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pwmDutyWord_r <= DUTY_RST;
			dutyStage_r   <= STAGE_RST;
			ctrl_r        <= CTRL_RST;
		end else begin
			if (stageLoad) begin
				dutyStage_r <= wData_r[13:8]; // RL13
			end
			if (dutyLoad) begin
				pwmDutyWord_r <= dutyNew; // RL13
			end
			if (wrCtrl & lowerLane) begin
				ctrl_r <= wData_r[6:0];
			end
		end
	end

	// ----------------------------------------
	// Conversion engine
	// ----------------------------------------
	// Duty and carrier are taken only at a cycle boundary so a running cycle
	// never mixes two settings; disabled, the shadows track live values.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dutyShadow_r    <= DUTY_RST;
			carrierShadow_r <= 1'b0;
		end else if (shadowLoad) begin
			dutyShadow_r    <= dutyLive;
			carrierShadow_r <= carrierLive;
		end
	end

	// Cleared while disabled so each enable starts a fresh unit
	always_ff @(posedge clock) begin
		if (sys_rst || !enable) begin
			prescaleCnt_r <= 14'h0000;
		end else if (unitTick) begin
			prescaleCnt_r <= 14'h0000; // RL11
		end else begin
			prescaleCnt_r <= prescaleCnt_r + 14'h0001;
		end
	end

	// Counters free-run; with low duty bits zero the pattern repeats sooner.
	always_ff @(posedge clock) begin
		if (sys_rst || !enable) begin
			unitCnt_r  <= 8'h00;
			pulseIdx_r <= 8'h00;
		end else if (unitTick) begin
			unitCnt_r <= unitLast ? 8'h00 : unitCnt_r + 8'h01; // RL3 RL5 RL11
			if (unitLast) begin
				pulseIdx_r <= pulseLast ? 8'h00 : pulseIdx_r + 8'h01; // RL1 RL9
			end
		end
	end

	// Reset parks the pin high, the inactive level without inversion
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pwm_output_pin <= 1'b1;
		end else begin
			pwm_output_pin <= pinNxt; // RL2 RL12
		end
	end

endmodule : pwm_dac

// file: bench/pwm_dac_chk.sv
// Port-level protocol checks for the PWM block.
module pwm_dac_chk (
	input wire logic                           clock,
	input wire logic                           sys_rst,
	input wire logic                           s_axi_awvalid,
	input wire logic                           s_axi_awready,
	input wire logic                           s_axi_wvalid,
	input wire logic                           s_axi_wready,
	input wire logic [1:0]                     s_axi_bresp,
	input wire logic                           s_axi_bvalid,
	input wire logic                           s_axi_bready,
	input wire logic [pwm_dac_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                           s_axi_arvalid,
	input wire logic                           s_axi_arready,
	input wire logic [31:0]                    s_axi_rdata,
	input wire logic [1:0]                     s_axi_rresp,
	input wire logic                           s_axi_rvalid,
	input wire logic                           s_axi_rready,
	input wire logic                           pwm_output_pin
);
	import pwm_dac_pkg::*;
	// ----------------------------------------
	// Handshake sequences
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_rd_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hc; endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_wr_resp; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_b_block: assert property (p_b_block) else $error("write taken while answer pending");
	property p_rd_resp; s_rd_taken |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_r_back; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	a_r_back: assert property (p_r_back) else $error("read channel not reopened");
	property p_unmapped; s_rd_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	// Reset state is checked even while reset is high
	property p_rst_state;
		disable iff (1'b0) sys_rst |=> pwm_output_pin && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
endmodule : pwm_dac_chk

bind pwm_dac pwm_dac_chk u_chk (.clock(clock), .sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwm_output_pin(pwm_output_pin));

// file: bench/pulse_division_pwm_dac_test.sv
// Self-checking bench for the PWM block.
module pulse_division_pwm_dac_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pwm_dac_pkg::*;
	`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failCount++; \
		$display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
	// ----------------------------------------
	// Signals and instance
	// ----------------------------------------
	localparam int LIMIT = 80000;
	logic              clock = 1'b0;
	logic              sys_rst = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              pwm_output_pin;
	logic [1:0]        lastResp;
	int                checked = 0, failCount = 0, cycles = 0;

	always #2 clock = ~clock;

	pwm_dac dut (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pwm_output_pin(pwm_output_pin));
	// ----------------------------------------
	// Bus and measurement tasks
	// ----------------------------------------
	task automatic report_and_stop;
		$display("checked %0d failed %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			failCount++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		lastResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Disable first so the new duty word lands at once, not at a cycle boundary
	task automatic setup(input logic [13:0] duty, input logic [6:0] ctrl);
		wr(OFS_CTRL, 32'h0, 4'hf);
		wr(OFS_DUTY, {18'h0, duty}, 4'h3);
		wr(OFS_CTRL, {25'h0, ctrl}, 4'h1);
		repeat (4) @(posedge clock);
	endtask : setup

	task automatic measure(input int n, output int hi, output int run);
		int cur;
		hi = 0;
		run = 0;
		cur = 0;
		repeat (n) begin
			@(posedge clock);
			if (pwm_output_pin === 1'b1) begin
				hi++;
				cur++;
				if (cur > run) run = cur;
			end else cur = 0;
		end
	endtask : measure
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		`CHK("pin after reset", 1'b1, pwm_output_pin)
		rd(OFS_CTRL, d, r);
		`CHK("ctrl reset", {25'h0, CTRL_RST}, d)
		rd(4'hc, d, r);
		`CHK("unmapped resp", RESP_SLVERR, r)
		wr(4'hc, 32'h0000_0000, 4'hf);
		`CHK("unmapped write resp", RESP_SLVERR, lastResp)
		wr(OFS_DUTY, 32'h0000_0200, 4'h2);
		`CHK("duty write resp", RESP_OKAY, lastResp)
		rd(OFS_DUTY, d, r);
		`CHK("duty staged only", {18'h0, DUTY_RST}, d)
		wr(OFS_DUTY, 32'h0000_0007, 4'h1);
		rd(OFS_DUTY, d, r);
		`CHK("duty committed", 32'h0000_0207, d)
	endtask : t_regs

	task automatic t_wave;
		int hi, run;
		setup(14'h0081, 7'h07);
		measure(16384, hi, run);
		`CHK("large total", 129, hi)
		`CHK("large longest", 3, run)
		setup(14'h0084, 7'h03);
		measure(4096, hi, run);
		`CHK("quarter low", 33, 4096 - hi)
		setup(14'h0304, 7'h05);
		measure(4096, hi, run);
		`CHK("small total", 193, hi)
		`CHK("small longest", 4, run)
		setup(14'h0000, 7'h05);
		measure(1024, hi, run);
		`CHK("zero inverted", 0, hi)
		setup(14'h003f, 7'h07);
		measure(1024, hi, run);
		`CHK("base field zero", 0, hi)
		setup(14'h0000, 7'h01);
		measure(1024, hi, run);
		`CHK("zero plain", 1024, hi)
	endtask : t_wave

	// Read latency adds a few clocks, so one or two units may pass
	// Each step restarts disabled so the unit count cannot wrap
	task automatic t_presc;
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  s1, diff;
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CTRL, 32'h0, 4'h1);
			wr(OFS_CTRL, {25'h0, 3'(3 + k), 4'hb}, 4'h1);
			rd(OFS_STATUS, d, r);
			s1 = d[7:0];
			repeat (256 << (2 * k)) @(posedge clock);
			rd(OFS_STATUS, d, r);
			diff = d[7:0] - s1;
			`CHK("prescale step", 1'b1, diff == 8'h01 || diff == 8'h02)
		end
	endtask : t_presc

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		t_regs();
		t_wave();
		t_presc();
		report_and_stop();
	end
endmodule : pulse_division_pwm_dac_test
